// [rtl/serial_sync_regs.svh]
// register map, field positions and reset values of the serial block
// How it works
// R1: sync clock follows the transmitter; no pulses during start or stop bits.
// R2: last data bit gets a clock pulse only when final_bit_pulse_sel is set.
// R3: clock_idle_level_sel sets clock polarity, clock_edge_phase_sel its phase.
// R4: sync clock stays inactive while idle, preamble or break.
// R5: clock options never touch the receiver.
// R6: with tx_on and rx_on both clear, clock and data pins float.
// R7: software sets clock options before enabling tx and leaves them.
// R8: status register is read-only, resets to tx_holding_empty and tx_done_flag.
// R9: tx_holding_empty sets on load to shifter; clears on status access then data write.
// R10: tx_done_flag sets after a data frame ends; same clear sequence.
// R11: rx_ready_flag sets when data readable; clears on status access then data read.
// R12: idle flag sets on quiet line, re-arms only after rx_ready_flag sets.
// R13: word arriving while rx_ready_flag set raises overrun, holding data kept.
// R14: noise_flag sets on noisy frame, no own interrupt, read-sequence clear.
// R15: framing_flag on bad stop bit; overrun alone when both occur.
// R16: parity_error_flag sets on bad parity, interrupts with parity_irq_on.
// R17: nine-bit words carry tx_ninth_bit out and rx_ninth_bit in.
// R18: serial_unit_off stops prescaler and outputs after the current word.
// R19: frame is start, eight or nine data bits, one stop bit.
// R20: wake from mute by quiet line when wake bit 0, address mark when 1.
// R21: parity_on puts parity at the MSB and checks it; applies next word.
// R22: parity_odd_sel picks even or odd parity; applies next word.
// R23: clock rests at its idle level; phase 0 mid-bit, phase 1 bit start.
// R24: 7 or 8 pulses per eight-bit word, 8 or 9 per nine-bit word.
// R25: one clock pulse per data bit except the last, which pulses only with final_bit_pulse_sel; aligned to the data by phase.
`ifndef SERIAL_SYNC_REGS_SVH
`define SERIAL_SYNC_REGS_SVH
`define OFS_STATUS 3'h0
`define OFS_DATA   3'h1
`define OFS_CTRL1  3'h2
`define OFS_CTRL2  3'h3
`define OFS_CTRL3  3'h4
`define OFS_BAUD   3'h5
`define STATUS_RST 8'hc0
`define BAUD_RST   8'h03
`define C2_TXIE  7
`define C2_TX_DONE_IRQ_ON  6
`define C2_RIE   5
`define C2_LINE_QUIET_IRQ_ON  4
`define C2_TE    3
`define C2_RE    2
`define C2_RWU   1
`define C3_CLKEN 3
`define C3_CLOCK_IDLE_LEVEL_SEL  2
`define C3_CLOCK_EDGE_PHASE_SEL  1
`define C3_FINAL_BIT_PULSE_SEL  0
`define OVS_LAST 4'hf
`define MID_SMP  4'h9
`define HALF_BIT 3
`define IDLE_T8  8'ha0
`define IDLE_T9  8'hb0
`endif

// [rtl/serial_sync_pkg.sv]
// types shared by the serial block
package serial_sync_pkg;
  typedef struct packed {
    logic rx9;
    logic tx9;
    logic off;
    logic nine;
    logic wake;
    logic parity_on;
    logic ps;
    logic parity_irq_on;
  } frame_ctrl_t;
  typedef struct packed {
    logic tx_holding_empty;
    logic tc;
    logic rx_ready_flag;
    logic idle;
    logic ovr;
    logic nf;
    logic fe;
    logic pe;
  } status_t;
  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} line_state_t;
endpackage : serial_sync_pkg

// [rtl/serial_sync_clock_status_ctrl.sv]
// serial transmitter/receiver with sync clock output and status flags
`timescale 1ns/100ps
`include "serial_sync_regs.svh"
module serial_sync_clock_status_ctrl #(
  parameter int DIV_W = 8
) (
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       RXD_IN,
  output logic            TXD_OUT,
  output logic            TXD_OE,
  output logic            SCLK_OUT,
  output logic            SCLK_OE,
  output logic            IRQ
);
  if (DIV_W < 2 || DIV_W > 8) begin : g_chk
    $error("DIV_W must be 2..8");
  end

  function automatic logic [8:0] fit_parity(input logic nine, input logic parity_on,
                                            input logic ps, input logic [8:0] w);
    logic [8:0] r;
    r = w;
    if (parity_on && nine) r[8] = ^w[7:0] ^ ps;
    if (parity_on && !nine) r[7] = ^w[6:0] ^ ps;
    return r;
  endfunction : fit_parity

  serial_sync_pkg::frame_ctrl_t cr1_r;
  serial_sync_pkg::status_t     st_r;
  serial_sync_pkg::line_state_t tx_st_r;
  serial_sync_pkg::line_state_t rx_st_r;
  logic [7:0]       cr2_r;
  logic [3:0]       cr3_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] bcnt_r;
  logic [7:0]       thr_r;
  logic [7:0]       rdr_r;
  logic             acc_r;
  logic [3:0]       tsub_r;
  logic [3:0]       tbit_r;
  logic [8:0]       tshf_r;
  logic             tnine_r;
  logic [3:0]       rsub_r;
  logic [3:0]       rbit_r;
  logic [8:0]       rshf_r;
  logic             rnine_r;
  logic             rpce_r;
  logic             rps_r;
  logic [1:0]       smp_r;
  logic             nz_r;
  logic [7:0]       quiet_r;
  logic             arm_r;
  logic             rxs1_r;
  logic             rxs2_r;

  // register decode
  wire wr_data = WR && ADDR == `OFS_DATA;
  wire rd_data = RD && ADDR == `OFS_DATA;
  wire clr_tx  = acc_r && wr_data;
  wire clr_rx  = acc_r && rd_data;
  wire te      = cr2_r[`C2_TE];
  wire re      = cr2_r[`C2_RE];
  wire clock_idle_level_sel    = cr3_r[`C3_CLOCK_IDLE_LEVEL_SEL];

  // prescaler halts only between words, so a word in flight completes
  wire quiet_all = tx_st_r == serial_sync_pkg::S_IDLE && rx_st_r == serial_sync_pkg::S_IDLE;
  wire stopped   = cr1_r.off && quiet_all; // see R18
  wire tick      = !stopped && bcnt_r == div_r;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) bcnt_r <= '0;
    else bcnt_r <= (stopped || tick) ? '0 : bcnt_r + 1'b1;
  end

  // transmitter
  wire tx_bend  = tick && tsub_r == `OVS_LAST;
  wire [3:0] tlast = tnine_r ? 4'h8 : 4'h7; // see R19
  wire tx_ready = te && !st_r.tx_holding_empty && !stopped;
  wire tx_load  = (tx_st_r == serial_sync_pkg::S_IDLE && tx_ready)
               || (tx_st_r == serial_sync_pkg::S_STOP && tx_bend && tx_ready); // see R9
  wire tx_fin   = tx_st_r == serial_sync_pkg::S_STOP && tx_bend && !tx_ready;
  // parity and word length sampled at load, so changes wait for the next word
  wire [8:0] tword = fit_parity(cr1_r.nine, cr1_r.parity_on, cr1_r.ps, {cr1_r.tx9, thr_r}); // see R17 R21 R22

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_st_r <= serial_sync_pkg::S_IDLE;
      tsub_r  <= '0;
      tbit_r  <= '0;
      tshf_r  <= '0;
      tnine_r <= 1'b0;
    end else if (tx_load) begin
      tx_st_r <= serial_sync_pkg::S_START;
      tsub_r  <= '0;
      tshf_r  <= tword;
      tnine_r <= cr1_r.nine;
    end else if (tick) begin
      tsub_r <= tsub_r + 4'h1;
      if (tx_bend) begin
        case (tx_st_r)
          serial_sync_pkg::S_START: begin
            tx_st_r <= serial_sync_pkg::S_DATA;
            tbit_r  <= '0;
          end
          serial_sync_pkg::S_DATA: begin
            tshf_r <= {1'b0, tshf_r[8:1]};
            tbit_r <= tbit_r + 4'h1;
            if (tbit_r == tlast) tx_st_r <= serial_sync_pkg::S_STOP;
          end
          serial_sync_pkg::S_STOP: tx_st_r <= serial_sync_pkg::S_IDLE;
          default: tx_st_r <= serial_sync_pkg::S_IDLE;
        endcase
      end
    end
  end

  // sync clock: only data bits pulse, last one only if asked
  wire pulse_en = tbit_r != tlast || cr3_r[`C3_FINAL_BIT_PULSE_SEL]; // see R2 R24
  wire act_half = cr3_r[`C3_CLOCK_EDGE_PHASE_SEL] ? !tsub_r[`HALF_BIT] : tsub_r[`HALF_BIT]; // see R23 R25
  wire clk_act  = tx_st_r == serial_sync_pkg::S_DATA && pulse_en && act_half; // see R1 R4
  wire sclk_nxt = clock_idle_level_sel ^ clk_act; // see R3
  wire txd_nxt  = tx_st_r == serial_sync_pkg::S_START ? 1'b0
                : tx_st_r == serial_sync_pkg::S_DATA ? tshf_r[0] : 1'b1;
  wire pins_on  = (te || re) && !stopped; // see R6 R18

  // receiver; clocking options are never consulted here
  wire rx_smp   = tick && rsub_r == `MID_SMP; // see R5
  wire maj      = (smp_r[0] & smp_r[1]) | (smp_r[0] & rxs2_r) | (smp_r[1] & rxs2_r);
  wire noisy    = !(smp_r[0] == smp_r[1] && smp_r[1] == rxs2_r);
  wire [3:0] rlast = rnine_r ? 4'h8 : 4'h7;
  wire rx_done  = rx_smp && rx_st_r == serial_sync_pkg::S_STOP;
  wire [8:0] rword = rnine_r ? rshf_r : {1'b0, rshf_r[8:1]};
  wire rmsb     = rnine_r ? rword[8] : rword[7];
  wire rbad_par = rpce_r && ((rnine_r ? ^rword[8:0] : ^rword[7:0]) != rps_r); // see R21 R22
  wire muted    = cr2_r[`C2_RWU];
  wire mark_wk  = rx_done && muted && cr1_r.wake && rmsb; // see R20
  wire deliver  = rx_done && (!muted || mark_wk);
  wire put      = deliver && !st_r.rx_ready_flag;
  wire ovr_set  = deliver && st_r.rx_ready_flag; // see R13
  wire [7:0] qlim = cr1_r.nine ? `IDLE_T9 : `IDLE_T8;
  wire quiet_hit = tick && rx_st_r == serial_sync_pkg::S_IDLE && re && quiet_r == qlim;
  wire idle_wk  = quiet_hit && muted && !cr1_r.wake; // see R20
  wire idle_set = quiet_hit && !muted && arm_r; // see R12

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxs1_r <= 1'b1;
      rxs2_r <= 1'b1;
    end else begin
      rxs1_r <= RXD_IN;
      rxs2_r <= rxs1_r;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_st_r <= serial_sync_pkg::S_IDLE;
      rsub_r  <= '0;
      rbit_r  <= '0;
      rshf_r  <= '0;
      rnine_r <= 1'b0;
      rpce_r  <= 1'b0;
      rps_r   <= 1'b0;
      smp_r   <= 2'b11;
      nz_r    <= 1'b0;
      quiet_r <= '0;
    end else if (!re) begin
      rx_st_r <= serial_sync_pkg::S_IDLE;
      quiet_r <= '0;
    end else if (tick) begin
      rsub_r <= rsub_r + 4'h1;
      smp_r  <= {smp_r[0], rxs2_r};
      if (rx_st_r != serial_sync_pkg::S_IDLE) quiet_r <= '0;
      else if (!rxs2_r) quiet_r <= '0;
      else if (quiet_r != qlim) quiet_r <= quiet_r + 8'h01;
      case (rx_st_r)
        serial_sync_pkg::S_IDLE:
          if (!rxs2_r) begin
            rx_st_r <= serial_sync_pkg::S_START;
            rsub_r  <= 4'h1;
            nz_r    <= 1'b0;
            rnine_r <= cr1_r.nine;
            rpce_r  <= cr1_r.parity_on;
            rps_r   <= cr1_r.ps;
          end
        serial_sync_pkg::S_START:
          if (rx_smp && maj) rx_st_r <= serial_sync_pkg::S_IDLE;
          else if (rsub_r == `OVS_LAST) begin
            rx_st_r <= serial_sync_pkg::S_DATA;
            rbit_r  <= '0;
          end
        serial_sync_pkg::S_DATA: begin
          if (rx_smp) begin
            rshf_r <= {maj, rshf_r[8:1]};
            nz_r   <= nz_r | noisy;
          end
          if (rsub_r == `OVS_LAST) begin
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r == rlast) rx_st_r <= serial_sync_pkg::S_STOP;
          end
        end
        // stop bit ends at mid-sample to catch a following start edge
        serial_sync_pkg::S_STOP:
          if (rx_smp) rx_st_r <= serial_sync_pkg::S_IDLE;
        default: rx_st_r <= serial_sync_pkg::S_IDLE;
      endcase
    end
  end

  // status flags: hardware set wins over the software clear sequence
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_r  <= `STATUS_RST; // see R8
      acc_r <= 1'b0;
      arm_r <= 1'b0;
      rdr_r <= '0;
    end else begin
      if (RD && ADDR == `OFS_STATUS) acc_r <= 1'b1;
      else if (wr_data || rd_data) acc_r <= 1'b0;
      st_r.tx_holding_empty <= tx_load | (st_r.tx_holding_empty & !clr_tx); // see R9
      st_r.tc   <= tx_fin | (st_r.tc & !clr_tx); // see R10
      st_r.rx_ready_flag <= put | (st_r.rx_ready_flag & !clr_rx); // see R11
      st_r.idle <= idle_set | (st_r.idle & !clr_rx); // see R12
      st_r.ovr  <= ovr_set | (st_r.ovr & !clr_rx); // see R13
      st_r.nf   <= (put && (nz_r || noisy)) | (st_r.nf & !clr_rx); // see R14
      st_r.fe   <= (put && !maj) | (st_r.fe & !clr_rx); // see R15
      st_r.pe   <= (put && rbad_par) | (st_r.pe & !clr_rx); // see R16
      if (put) rdr_r <= rword[7:0];
      if (put) arm_r <= 1'b1;
      else if (idle_set) arm_r <= 1'b0;
    end
  end

  // control registers; status offset ignores writes
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cr1_r <= '0;
      cr2_r <= '0;
      cr3_r <= '0;
      div_r <= DIV_W'(`BAUD_RST);
      thr_r <= '0;
    end else begin
      if (WR && ADDR == `OFS_CTRL1) cr1_r <= {cr1_r.rx9, WDATA[6:0]};
      if (put) cr1_r.rx9 <= rword[8]; // see R17
      if (WR && ADDR == `OFS_CTRL2) cr2_r <= WDATA;
      else if (mark_wk || idle_wk) cr2_r[`C2_RWU] <= 1'b0; // see R20
      if (WR && ADDR == `OFS_CTRL3) cr3_r <= WDATA[3:0];
      if (WR && ADDR == `OFS_BAUD) div_r <= WDATA[DIV_W-1:0];
      if (wr_data) thr_r <= WDATA;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    case (ADDR)
      `OFS_STATUS: rd_mux = st_r;
      `OFS_DATA:   rd_mux = rdr_r;
      `OFS_CTRL1:  rd_mux = cr1_r;
      `OFS_CTRL2:  rd_mux = cr2_r;
      `OFS_CTRL3:  rd_mux = {4'h0, cr3_r};
      `OFS_BAUD:   rd_mux = 8'(div_r);
      default:     rd_mux = 8'h00;
    endcase
  end

  wire irq_nxt = (st_r.tx_holding_empty & cr2_r[`C2_TXIE]) | (st_r.tc & cr2_r[`C2_TX_DONE_IRQ_ON])
               | ((st_r.rx_ready_flag | st_r.ovr) & cr2_r[`C2_RIE])
               | (st_r.idle & cr2_r[`C2_LINE_QUIET_IRQ_ON]) | (st_r.pe & cr1_r.parity_irq_on);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA    <= '0;
      TXD_OUT  <= 1'b1;
      TXD_OE   <= 1'b0;
      SCLK_OUT <= 1'b0;
      SCLK_OE  <= 1'b0;
      IRQ      <= 1'b0;
    end else begin
      RDATA    <= RD ? rd_mux : 8'h00;
      TXD_OUT  <= txd_nxt;
      TXD_OE   <= pins_on; // see R6
      SCLK_OUT <= sclk_nxt;
      SCLK_OE  <= pins_on && cr3_r[`C3_CLKEN];
      IRQ      <= irq_nxt;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  property p_no_clk_out;
    tx_st_r != serial_sync_pkg::S_DATA |=> SCLK_OUT == $past(clock_idle_level_sel);
  endproperty
  a_no_clk_out: assert property (p_no_clk_out) else $error("sclk pulsed outside data"); // see R1 R4
  property p_last_bit;
    tx_st_r == serial_sync_pkg::S_DATA && tbit_r == tlast && !cr3_r[`C3_FINAL_BIT_PULSE_SEL] |=> SCLK_OUT == $past(clock_idle_level_sel);
  endproperty
  a_last_bit: assert property (p_last_bit) else $error("last bit pulse not suppressed"); // see R2
  property p_phase;
    tx_st_r == serial_sync_pkg::S_DATA && pulse_en && tsub_r == 4'hc && !cr3_r[`C3_CLOCK_EDGE_PHASE_SEL] |=> SCLK_OUT != $past(clock_idle_level_sel);
  endproperty
  a_phase: assert property (p_phase) else $error("phase 0 clock not active late in bit"); // see R3 R23
  property p_hiz;
    !(te || re) |=> !TXD_OE && !SCLK_OE;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins driven while disabled"); // see R6
  property p_tx_holding_empty;
    tx_load |=> st_r.tx_holding_empty ##1 tx_st_r != serial_sync_pkg::S_IDLE;
  endproperty
  a_tx_holding_empty: assert property (p_tx_holding_empty) else $error("empty flag not set on load"); // see R9
  property p_tc;
    tx_fin |=> st_r.tc && tx_st_r == serial_sync_pkg::S_IDLE;
  endproperty
  a_tc: assert property (p_tc) else $error("done flag missing"); // see R10
  property p_rx_ready_flag_clear;
    st_r.rx_ready_flag && clr_rx && !put |=> !st_r.rx_ready_flag;
  endproperty
  a_rx_ready_flag_clear: assert property (p_rx_ready_flag_clear) else $error("ready flag not cleared"); // see R11
  property p_overrun;
    ovr_set |=> st_r.ovr && $stable(rdr_r) && !$rose(st_r.fe);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun handling wrong"); // see R13 R15
  property p_idle_rearm;
    idle_set |=> !arm_r;
  endproperty
  a_idle_rearm: assert property (p_idle_rearm) else $error("idle not disarmed"); // see R12
  property p_txd_start;
    tx_st_r == serial_sync_pkg::S_START |=> !TXD_OUT;
  endproperty
  a_txd_start: assert property (p_txd_start) else $error("start bit not low"); // see R19

  c_frame_done: cover property (tx_fin);
  c_overrun: cover property (ovr_set);
  c_clk_pulse: cover property ($rose(SCLK_OUT) && !clock_idle_level_sel);
  c_rx_put: cover property (put ##[1:300] clr_rx);
endmodule : serial_sync_clock_status_ctrl

// [bench/serial_peer_model.sv]
// far-side peer: shift register clocked by the sync clock, plus a serial sender
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic sclk,
  input  wire logic txd,
  input  wire logic pol,
  input  wire logic pha,
  output logic      rxd
);
  int         pulses;
  logic [8:0] cap;
  initial begin
    rxd = 1'b1;
    pulses = 0;
    cap = '0;
  end
  // mid-bit edge: leaving rest for phase 0, returning for phase 1
  always @(sclk) begin
    if (sclk !== pol) pulses++;
    if (((sclk !== pol) == (pha == 1'b0)) && pulses > 0 && pulses < 10) cap[pulses - 1] = txd;
  end
  task automatic clear;
    pulses = 0;
    cap = '0;
  endtask : clear
  // short low stop so a bad stop cannot pose as a new start bit
  task automatic send_word(input logic [8:0] w, input int n, input logic stop, input int bns);
    rxd = 1'b0;
    #bns;
    for (int i = 0; i < n; i++) begin
      rxd = w[i];
      #bns;
    end
    rxd = stop;
    #(bns * 5 / 8);
    rxd = 1'b1;
    #(bns * 11 / 8);
  endtask : send_word
endmodule : serial_peer_model

// [bench/testbench.sv]
// self-checking bench: sync clock, status flags and frame control
`timescale 1ns/100ps
module testbench;
  localparam int BNS = 256;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       rxd, txd, txd_oe, sclk, sclk_oe, irq;
  logic       pol = 1'b0;
  logic       pha = 1'b0;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  always #4 clk = ~clk;
  serial_sync_clock_status_ctrl #(.DIV_W(8)) dut_u (
    .REF_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD_IN(rxd), .TXD_OUT(txd), .TXD_OE(txd_oe), .SCLK_OUT(sclk),
    .SCLK_OE(sclk_oe), .IRQ(irq));
  serial_peer_model peer_u (.sclk(sclk), .txd(txd), .pol(pol), .pha(pha), .rxd(rxd));
  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // each poll is a status read, so it also arms the clearing sequence
  task automatic wait_flag(input logic [7:0] m, output logic [7:0] s);
    for (int i = 0; i < 3000; i++) begin
      rd_reg(3'h0, s);
      if ((s & m) != 8'h00) return;
    end
    fail_count++;
    $display("BAD t=%0t flag %h never set", $time, m);
  endtask : wait_flag
  task automatic t_reset;
    logic [7:0] s;
    rd_reg(3'h0, s);
    check({1'b0, s}, 9'h0c0, "status reset");
    wr_reg(3'h0, 8'h00);
    rd_reg(3'h0, s);
    check({1'b0, s}, 9'h0c0, "status ro");
    rd_reg(3'h6, s);
    check({1'b0, s}, 9'h000, "unmapped");
    check({6'h0, irq, txd_oe, sclk_oe}, 9'h0, "pins after reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx;
    logic [7:0] c1 [6] = '{8'h00, 8'h00, 8'h50, 8'h10, 8'h06, 8'h04};
    logic [7:0] c3 [6] = '{8'h08, 8'h0d, 8'h0b, 8'h0a, 8'h09, 8'h09};
    logic [7:0] dat [6] = '{8'ha5, 8'h3c, 8'h96, 8'h5a, 8'h03, 8'h07};
    logic [8:0] ecap [6] = '{9'h025, 9'h03c, 9'h196, 9'h05a, 9'h083, 9'h087};
    int npl [6] = '{7, 8, 9, 8, 8, 8};
    logic [7:0] s;
    for (int i = 0; i < 6; i++) begin
      wr_reg(3'h3, 8'h00);
      repeat (3) @(posedge clk);
      check({7'h0, txd_oe, sclk_oe}, 9'h0, "pins float");
      wr_reg(3'h2, c1[i]);
      wr_reg(3'h4, c3[i]);
      pol = c3[i][2];
      pha = c3[i][1];
      wr_reg(3'h3, 8'h0c);
      repeat (4) @(posedge clk);
      check({8'h0, sclk}, {8'h0, pol}, "clock rest");
      check({7'h0, txd_oe, sclk_oe}, 9'h3, "pins driven");
      peer_u.clear();
      rd_reg(3'h0, s);
      wr_reg(3'h1, dat[i]);
      rd_reg(3'h0, s);
      check({8'h0, s[6]}, 9'h0, "done cleared");
      wait_flag(8'h40, s);
      check({8'h0, s[7]}, 9'h1, "holding empty");
      check(9'(peer_u.pulses), 9'(npl[i]), "pulse count");
      check(peer_u.cap, ecap[i], "clocked bits");
    end
    wr_reg(3'h3, 8'hcc);
    repeat (3) @(posedge clk);
    check({8'h0, irq}, 9'h1, "tx irq");
    wr_reg(3'h2, 8'h20);
    repeat (3) @(posedge clk);
    check({8'h0, txd_oe}, 9'h0, "unit off");
    wr_reg(3'h2, 8'h00);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx_idle;
    logic [7:0] s;
    wr_reg(3'h3, 8'h2c);
    peer_u.send_word(9'h0c3, 8, 1'b1, BNS);
    wait_flag(8'h20, s);
    check({8'h0, irq}, 9'h1, "rx irq");
    rd_reg(3'h1, s);
    check({1'b0, s}, 9'h0c3, "rx data");
    rd_reg(3'h0, s);
    check({8'h0, s[5]}, 9'h0, "ready cleared");
    wait_flag(8'h10, s);
    rd_reg(3'h1, s);
    repeat (900) @(posedge clk);
    rd_reg(3'h0, s);
    check({8'h0, s[4]}, 9'h0, "idle once");
    $display("test rx idle done");
  endtask : t_rx_idle
  task automatic t_rx_ovr;
    logic [7:0] s;
    peer_u.send_word(9'h011, 8, 1'b1, BNS);
    peer_u.send_word(9'h022, 8, 1'b0, BNS);
    wait_flag(8'h08, s);
    check({1'b0, s & 8'h2a}, 9'h028, "overrun only");
    rd_reg(3'h1, s);
    check({1'b0, s}, 9'h011, "kept data");
    $display("test overrun done");
  endtask : t_rx_ovr
  task automatic t_rx_tab;
    logic [7:0] c1 [3] = '{8'h00, 8'h05, 8'h10};
    logic [8:0] w [3] = '{9'h055, 9'h001, 9'h1a5};
    logic [7:0] st [3] = '{8'h22, 8'h21, 8'h20};
    logic [7:0] s;
    wr_reg(3'h3, 8'h0c);
    for (int i = 0; i < 3; i++) begin
      wr_reg(3'h2, c1[i]);
      peer_u.send_word(w[i], (i == 2) ? 9 : 8, i != 0, BNS);
      wait_flag(8'h20, s);
      check({1'b0, s & 8'h2f}, {1'b0, st[i]}, "rx flags");
      check({8'h0, irq}, {8'h0, i == 1}, "parity irq");
      rd_reg(3'h1, s);
      check({1'b0, s}, {1'b0, w[i][7:0]}, "rx word");
      rd_reg(3'h2, s);
      check({8'h0, s[7]}, {8'h0, w[i][8]}, "ninth in");
    end
    $display("test rx table done");
  endtask : t_rx_tab
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    wr_reg(3'h5, 8'h01);
    t_tx();
    t_rx_idle();
    t_rx_ovr();
    t_rx_tab();
    give_verdict();
  end
  // whole run needs well under 20000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("BAD t=%0t run too long", $time);
      give_verdict();
    end
  end
endmodule : testbench
